// ==== ebs_sequencer.sv ====
// External brake sequencer with AXI4-Lite register access
//
// Summary of operation
// - On stop, ramp down to brake frequency first
// - At brake frequency, drop release output
// - Then time confirmation, holding brake frequency
// - Confirmation still high at expiry: engage fault
// - Confirmation drop starts pre-stop wait
// - Pre-stop wait over: ramp output to zero
// - Start: release delay after brake frequency reached
// - Start: pre-acceleration delay after confirmation
// - Brake frequency settable 0 to 400 Hz
// - Release only at or above minimum current, 0-2x rated
// - Confirmation mapped to input 1-8, code 44
// - Release mapped to output 11-15, code 19
// - Fault mapped to output 11-15, code 20
// - Fault does not stop the motor
// - Current reached at delay end: release brake
// - Current not reached: raise fault instead
// - After release, wait for confirmation
// - No confirmation in time: release fault
`timescale 1ns/10ps
`default_nettype none
`include "ebs_defines.svh"

module ebs_sequencer #(
  parameter int unsigned TICK_CYCLES = `EBS_TICK_CYCLES
) (
  input wire logic CLK, // System clock, 10 MHz
  input wire logic SYS_RST, // Synchronous reset, high
  input wire logic RUN_REQ, // Run command, low means stop
  input wire logic [15:0] OUT_FREQ, // Output frequency, 0.1 Hz
  input wire logic [15:0] MOTOR_CUR, // Motor current, 0.1 % rated
  input wire logic [7:0] DIN, // Digital input pins 1 to 8
  output logic [4:0] DOUT, // Digital outputs 11 to 15
  output logic RELEASE_BRAKE_OUT, // Release brake state
  output logic BRAKE_FAULT_OUT, // Brake fault state
  output logic [7:0] FAULT_CODE, // Last fault code
  output logic FREQ_OVERRIDE, // Ramp follows FREQ_TARGET
  output logic [15:0] FREQ_TARGET, // Override target, 0.1 Hz
  input wire logic [7:0] S_AXI_AWADDR, // Write address
  input wire logic S_AXI_AWVALID, // Write address valid
  output logic S_AXI_AWREADY, // Write address ready
  input wire logic [31:0] S_AXI_WDATA, // Write data
  input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes
  input wire logic S_AXI_WVALID, // Write data valid
  output logic S_AXI_WREADY, // Write data ready
  output logic [1:0] S_AXI_BRESP, // Write response
  output logic S_AXI_BVALID, // Write response valid
  input wire logic S_AXI_BREADY, // Write response ready
  input wire logic [7:0] S_AXI_ARADDR, // Read address
  input wire logic S_AXI_ARVALID, // Read address valid
  output logic S_AXI_ARREADY, // Read address ready
  output logic [31:0] S_AXI_RDATA, // Read data
  output logic [1:0] S_AXI_RRESP, // Read response
  output logic S_AXI_RVALID, // Read data valid
  input wire logic S_AXI_RREADY // Read data ready
);

  ////////////////////////////////////////////////////////////////////////
  // Constants and parameter check

  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1); // Prescaler end
  localparam logic [8:0] DLY_MAX = 9'(`EBS_DELAY_MAX_TICKS); // 5 s
  localparam logic [15:0] FREQ_MAX = 16'(`EBS_FREQ_MAX); // 400 Hz
  localparam logic [15:0] CUR_MAX = 16'(`EBS_CUR_MAX); // 2x rated

  // Prescaler is 17 bits wide
  if (TICK_CYCLES < 2 || TICK_CYCLES > 131072) begin : g_chk
    $error("TICK_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // State and derived terms

  ebs_pkg::ebs_state_t state_reg; // All registered state
  ebs_pkg::ebs_state_t state_next; // Its next value
  logic tick; // 10 ms tick
  logic confirm; // Brake confirmation after mapping
  logic exp_rel; // Release delay over
  logic exp_acc; // Pre-acceleration delay over
  logic exp_stp; // Pre-stop delay over
  logic exp_cnf; // Confirmation time over
  logic cur_ok; // Current at or above threshold

  // Fixed 10 ms tick from the system clock
  assign tick = (state_reg.pre == TICK_LAST);
  assign exp_rel = (state_reg.ticks >= state_reg.rel_dly);
  assign exp_acc = (state_reg.ticks >= state_reg.acc_dly);
  assign exp_stp = (state_reg.ticks >= state_reg.stp_dly);
  assign exp_cnf = (state_reg.ticks >= state_reg.cnf_dly);
  assign cur_ok = (MOTOR_CUR >= state_reg.brake_cur);

  // Any input selected with the confirmation code feeds the sequence
  always_comb begin
    confirm = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (state_reg.in_sel[i] == `EBS_FN_CONFIRM) begin
        confirm = confirm | state_reg.din[i];
      end
    end
  end

  // Byte lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Clamp a delay to 5 s
  function automatic logic [8:0] clamp_dly(input logic [31:0] v);
    return (v > 32'(DLY_MAX)) ? DLY_MAX : v[8:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [31:0] wv; // Merged write value
    logic [7:0] wa; // Write address
    logic [7:0] ra; // Read address
    wv = 32'h0000_0000;
    wa = state_reg.awaddr;
    ra = S_AXI_ARADDR;
    state_next = state_reg;

    // Input pins through three flops, change taken when last two agree
    state_next.s1 = DIN;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.din = (~(state_reg.s2 ^ state_reg.s3) & state_reg.s2)
                   | ((state_reg.s2 ^ state_reg.s3) & state_reg.din);

    // Prescaler and tick counter, counter saturates
    state_next.pre = tick ? 17'h00000 : 17'(state_reg.pre + 17'h00001);
    if (tick && state_reg.ticks != 9'h1FF) begin
      state_next.ticks = 9'(state_reg.ticks + 9'h001);
    end

    // Write channel: address and data taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = S_AXI_AWADDR;
      wa = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      state_next.w_got = 1'b1;
      state_next.wdata = S_AXI_WDATA;
      state_next.wstrb = S_AXI_WSTRB;
    end
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      state_next.bvalid = 1'b0;
    end

    // Perform the write once both halves are held
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = 2'h0;
      wv = merge(32'h0000_0000, state_reg.wdata, state_reg.wstrb);
      unique case (wa)
        `EBS_REG_CTRL: begin
          if (state_reg.wstrb[0]) begin
            state_next.en = wv[`EBS_CTRL_EN_BIT];
            // Software clear; a fault raised below still wins
            if (wv[`EBS_CTRL_CLR_BIT]) begin
              state_next.flt = 1'b0;
              state_next.code = 8'h00;
            end
          end
        end
        `EBS_REG_REL_DLY: state_next.rel_dly = clamp_dly(
          merge(32'(state_reg.rel_dly), state_reg.wdata, state_reg.wstrb));
        `EBS_REG_ACC_DLY: state_next.acc_dly = clamp_dly(
          merge(32'(state_reg.acc_dly), state_reg.wdata, state_reg.wstrb));
        `EBS_REG_STP_DLY: state_next.stp_dly = clamp_dly(
          merge(32'(state_reg.stp_dly), state_reg.wdata, state_reg.wstrb));
        `EBS_REG_CNF_DLY: state_next.cnf_dly = clamp_dly(
          merge(32'(state_reg.cnf_dly), state_reg.wdata, state_reg.wstrb));
        `EBS_REG_BRAKE_FREQ: begin
          wv = merge(32'(state_reg.brake_freq), state_reg.wdata,
                     state_reg.wstrb);
          state_next.brake_freq = (wv > 32'(FREQ_MAX)) ? FREQ_MAX
                                                     : wv[15:0];
        end
        `EBS_REG_BRAKE_CUR: begin
          wv = merge(32'(state_reg.brake_cur), state_reg.wdata,
                     state_reg.wstrb);
          state_next.brake_cur = (wv > 32'(CUR_MAX)) ? CUR_MAX
                                                   : wv[15:0];
        end
        `EBS_REG_STATUS, `EBS_REG_INPUTS: begin
          // Read-only, write ignored
        end
        default: begin
          if (wa[7:5] == `EBS_REG_IN_SEL && state_reg.wstrb[0]) begin
            state_next.in_sel[wa[4:2]] = state_reg.wdata[7:0];
          end else if (wa[7:5] == `EBS_REG_OUT_SEL && wa[4:2] < 3'h5) begin
            if (state_reg.wstrb[0]) begin
              state_next.out_sel[wa[4:2]] = state_reg.wdata[7:0];
            end
          end else begin
            state_next.bresp = 2'h2;
          end
        end
      endcase
    end

    // Read channel: answer one cycle after the address is taken
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      state_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = 2'h0;
      state_next.rdata = 32'h0000_0000;
      unique case (ra)
        `EBS_REG_CTRL: state_next.rdata[0] = state_reg.en;
        `EBS_REG_REL_DLY: state_next.rdata[8:0] = state_reg.rel_dly;
        `EBS_REG_ACC_DLY: state_next.rdata[8:0] = state_reg.acc_dly;
        `EBS_REG_STP_DLY: state_next.rdata[8:0] = state_reg.stp_dly;
        `EBS_REG_CNF_DLY: state_next.rdata[8:0] = state_reg.cnf_dly;
        `EBS_REG_BRAKE_FREQ: state_next.rdata[15:0] = state_reg.brake_freq;
        `EBS_REG_BRAKE_CUR: state_next.rdata[15:0] = state_reg.brake_cur;
        `EBS_REG_STATUS: state_next.rdata = {state_reg.code, 6'h00,
          state_reg.flt, state_reg.rel, 5'h00, state_reg.fsm};
        `EBS_REG_INPUTS: state_next.rdata = {23'h000000, confirm,
                                             state_reg.din};
        default: begin
          if (ra[7:5] == `EBS_REG_IN_SEL) begin
            state_next.rdata[7:0] = state_reg.in_sel[ra[4:2]];
          end else if (ra[7:5] == `EBS_REG_OUT_SEL && ra[4:2] < 3'h5) begin
            state_next.rdata[7:0] = state_reg.out_sel[ra[4:2]];
          end else begin
            state_next.rresp = 2'h2;
          end
        end
      endcase
    end

    // Brake sequence
    unique case (state_reg.fsm)
      ebs_pkg::S_IDLE: begin
        if (state_reg.en && RUN_REQ) begin
          state_next.fsm = ebs_pkg::S_RAMP;
        end
      end
      ebs_pkg::S_RAMP: begin
        // Accelerate to brake frequency, brake still closed
        if (!RUN_REQ) begin
          state_next.fsm = ebs_pkg::S_SZERO;
        end else if (OUT_FREQ >= state_reg.brake_freq) begin
          state_next.fsm = ebs_pkg::S_RELW;
        end
      end
      ebs_pkg::S_RELW: begin
        if (!RUN_REQ) begin
          state_next.fsm = ebs_pkg::S_SZERO;
        end else if (exp_rel && cur_ok) begin
          state_next.rel = 1'b1;
          state_next.fsm = ebs_pkg::S_CONF;
        end else if (exp_rel) begin
          state_next.flt = 1'b1;
          state_next.fsm = ebs_pkg::S_FAULT;
        end
      end
      ebs_pkg::S_CONF: begin
        if (confirm) begin
          state_next.fsm = ebs_pkg::S_PREAC;
        end else if (exp_cnf) begin
          state_next.rel = 1'b0;
          state_next.flt = 1'b1;
          state_next.code = `EBS_CODE_RELEASE_FAIL;
          state_next.fsm = ebs_pkg::S_FAULT;
        end else if (!RUN_REQ) begin
          state_next.fsm = ebs_pkg::S_SRAMP;
        end
      end
      ebs_pkg::S_PREAC: begin
        if (!RUN_REQ) begin
          state_next.fsm = ebs_pkg::S_SRAMP;
        end else if (exp_acc) begin
          state_next.fsm = ebs_pkg::S_RUN;
        end
      end
      ebs_pkg::S_RUN: begin
        if (!RUN_REQ) begin
          state_next.fsm = ebs_pkg::S_SRAMP;
        end
      end
      ebs_pkg::S_SRAMP: begin
        // Brake outputs untouched until brake frequency reached
        if (OUT_FREQ <= state_reg.brake_freq) begin
          state_next.rel = 1'b0;
          state_next.fsm = ebs_pkg::S_SCONF;
        end
      end
      ebs_pkg::S_SCONF: begin
        // Brake is expected to drop confirmation in this window
        if (!confirm) begin
          state_next.fsm = ebs_pkg::S_SPRE;
        end else if (exp_cnf) begin
          state_next.flt = 1'b1;
          state_next.code = `EBS_CODE_ENGAGE_FAIL;
          state_next.fsm = ebs_pkg::S_FAULT;
        end
      end
      ebs_pkg::S_SPRE: begin
        if (exp_stp) begin
          state_next.fsm = ebs_pkg::S_SZERO;
        end
      end
      ebs_pkg::S_SZERO: begin
        if (OUT_FREQ == 16'h0000) begin
          state_next.fsm = ebs_pkg::S_IDLE;
        end
      end
      ebs_pkg::S_FAULT: begin
        // Leave after software clear and with the run command off, or when disabled
        if (!state_next.flt && !RUN_REQ) begin
          state_next.fsm = ebs_pkg::S_IDLE;
        end
      end
      default: begin
        state_next.fsm = ebs_pkg::S_IDLE;
      end
    endcase

    // Disabled: sequence parked, both outputs low
    if (!state_reg.en) begin
      state_next.fsm = ebs_pkg::S_IDLE;
      state_next.rel = 1'b0;
      state_next.flt = 1'b0;
    end

    // Every state entry restarts the timer
    if (state_next.fsm != state_reg.fsm) begin
      state_next.pre = 17'h00000;
      state_next.ticks = 9'h000;
    end

    // Ramp override: none when idle, running or faulted
    state_next.ovr = !(state_next.fsm inside {ebs_pkg::S_IDLE,
      ebs_pkg::S_RUN, ebs_pkg::S_FAULT});
    state_next.tgt = (state_next.fsm == ebs_pkg::S_SZERO) ? 16'h0000
                     : state_next.brake_freq;

    // Output terminal mapping
    for (int k = 0; k < 5; k++) begin
      state_next.dout[k] =
        (state_reg.out_sel[k] == `EBS_FN_RELEASE && state_next.rel) ||
        (state_reg.out_sel[k] == `EBS_FN_FAULT && state_next.flt);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_reg <= '0;
      state_reg.fsm <= ebs_pkg::S_IDLE;
      state_reg.rel_dly <= `EBS_RST_DLY;
      state_reg.acc_dly <= `EBS_RST_DLY;
      state_reg.stp_dly <= `EBS_RST_DLY;
      state_reg.cnf_dly <= `EBS_RST_DLY;
      state_reg.brake_freq <= `EBS_RST_FREQ;
      state_reg.brake_cur <= `EBS_RST_CUR;
      state_reg.in_sel <= {8{`EBS_RST_SEL}};
      state_reg.out_sel <= {5{`EBS_RST_SEL}};
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign DOUT = state_reg.dout;
  assign RELEASE_BRAKE_OUT = state_reg.rel;
  assign BRAKE_FAULT_OUT = state_reg.flt;
  assign FAULT_CODE = state_reg.code;
  assign FREQ_OVERRIDE = state_reg.ovr;
  assign FREQ_TARGET = state_reg.tgt;
  assign S_AXI_AWREADY = !state_reg.aw_got && !state_reg.bvalid;
  assign S_AXI_WREADY = !state_reg.w_got && !state_reg.bvalid;
  assign S_AXI_BVALID = state_reg.bvalid;
  assign S_AXI_BRESP = state_reg.bresp;
  assign S_AXI_ARREADY = !state_reg.rvalid;
  assign S_AXI_RVALID = state_reg.rvalid;
  assign S_AXI_RDATA = state_reg.rdata;
  assign S_AXI_RRESP = state_reg.rresp;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  a_release_needs_current: assert property (@(posedge CLK)
    disable iff (SYS_RST) $rose(state_reg.rel) |->
      $past(cur_ok) && $past(state_reg.fsm) == ebs_pkg::S_RELW)
    else $error("Brake released without current");
  a_low_current_fault: assert property (@(posedge CLK)
    disable iff (SYS_RST) state_reg.en && state_reg.fsm == ebs_pkg::S_RELW
      && RUN_REQ && exp_rel && !cur_ok |=> state_reg.flt && !state_reg.rel)
    else $error("Low current did not raise fault");
  a_stop_release_drop: assert property (@(posedge CLK)
    disable iff (SYS_RST) state_reg.en && state_reg.fsm == ebs_pkg::S_SRAMP
      && OUT_FREQ <= state_reg.brake_freq |=> !state_reg.rel
      && state_reg.fsm == ebs_pkg::S_SCONF && state_reg.ticks == 9'h000)
    else $error("Release not dropped at brake frequency");
  a_confirm_hold_freq: assert property (@(posedge CLK)
    disable iff (SYS_RST) state_reg.fsm == ebs_pkg::S_SCONF |->
      state_reg.ovr && state_reg.tgt == state_reg.brake_freq)
    else $error("Brake frequency not held");
  a_engage_fail_code: assert property (@(posedge CLK)
    disable iff (SYS_RST) state_reg.en && state_reg.fsm == ebs_pkg::S_SCONF
      && confirm && exp_cnf |=> state_reg.flt
      && state_reg.code == `EBS_CODE_ENGAGE_FAIL)
    else $error("Engage failure not reported");
  a_prestop_start: assert property (@(posedge CLK)
    disable iff (SYS_RST) state_reg.en && state_reg.fsm == ebs_pkg::S_SCONF
      && !confirm |=> state_reg.fsm == ebs_pkg::S_SPRE ##1
      state_reg.ticks == 9'h000 || state_reg.fsm != ebs_pkg::S_SPRE)
    else $error("Pre-stop wait not started");
  a_zero_target: assert property (@(posedge CLK)
    disable iff (SYS_RST) state_reg.fsm == ebs_pkg::S_SZERO |->
      state_reg.ovr && state_reg.tgt == 16'h0000)
    else $error("Zero ramp target missing");
  a_release_fail: assert property (@(posedge CLK)
    disable iff (SYS_RST) state_reg.en && state_reg.fsm == ebs_pkg::S_CONF
      && !confirm && exp_cnf |=> !state_reg.rel && state_reg.flt
      && state_reg.code == `EBS_CODE_RELEASE_FAIL)
    else $error("Release failure not reported");
  a_disabled_quiet: assert property (@(posedge CLK)
    disable iff (SYS_RST) !state_reg.en |=> !state_reg.rel
      && !state_reg.flt ##1 !state_reg.ovr || state_reg.en)
    else $error("Outputs active while disabled");
  a_fault_no_stop: assert property (@(posedge CLK)
    disable iff (SYS_RST) state_reg.fsm == ebs_pkg::S_FAULT |-> !state_reg.ovr)
    else $error("Fault state overrides ramp");

endmodule
`default_nettype wire

// ==== ebs_defines.svh ====
// Constants for the external brake sequencer: map, codes, reset values, timing
`ifndef EBS_DEFINES_SVH
`define EBS_DEFINES_SVH

// Clock and timer tick
`define EBS_CLK_HZ 10000000
`define EBS_TICK_MS 10
`define EBS_TICK_CYCLES (`EBS_CLK_HZ / 1000 * `EBS_TICK_MS)
`define EBS_DELAY_MAX_S 5
`define EBS_DELAY_MAX_TICKS (`EBS_DELAY_MAX_S * 1000 / `EBS_TICK_MS)

// Frequency in 0.1 Hz units, current in 0.1 % of rated current
`define EBS_FREQ_MAX_HZ 400
`define EBS_FREQ_MAX (`EBS_FREQ_MAX_HZ * 10)
`define EBS_CUR_RATED 1000
`define EBS_CUR_MAX_X 2
`define EBS_CUR_MAX (`EBS_CUR_MAX_X * `EBS_CUR_RATED)

// Register byte offsets; the two select banks by address bits 7:5
`define EBS_REG_CTRL 8'h00
`define EBS_REG_REL_DLY 8'h04
`define EBS_REG_ACC_DLY 8'h08
`define EBS_REG_STP_DLY 8'h0C
`define EBS_REG_CNF_DLY 8'h10
`define EBS_REG_BRAKE_FREQ 8'h14
`define EBS_REG_BRAKE_CUR 8'h18
`define EBS_REG_STATUS 8'h1C
`define EBS_REG_INPUTS 8'h20
`define EBS_REG_IN_SEL 3'h2
`define EBS_REG_OUT_SEL 3'h3

// Control fields
`define EBS_CTRL_EN_BIT 0
`define EBS_CTRL_CLR_BIT 1

// Function and fault codes
`define EBS_FN_CONFIRM 8'h2C
`define EBS_FN_RELEASE 8'h13
`define EBS_FN_FAULT 8'h14
`define EBS_CODE_ENGAGE_FAIL 8'h24
`define EBS_CODE_RELEASE_FAIL 8'h20

// Reset values
`define EBS_RST_DLY 9'h000
`define EBS_RST_FREQ 16'h0000
`define EBS_RST_CUR 16'h03E8
`define EBS_RST_SEL 8'h00

`endif

// ==== ebs_pkg.sv ====
// Types for the external brake sequencer
`default_nettype none
package ebs_pkg;

  // Sequencer states, one-hot
  typedef enum logic [10:0] {
    S_IDLE  = 11'h001,
    S_RAMP  = 11'h002,
    S_RELW  = 11'h004,
    S_CONF  = 11'h008,
    S_PREAC = 11'h010,
    S_RUN   = 11'h020,
    S_SRAMP = 11'h040,
    S_SCONF = 11'h080,
    S_SPRE  = 11'h100,
    S_SZERO = 11'h200,
    S_FAULT = 11'h400
  } ebs_fsm_t;

  // Whole state of the sequencer
  typedef struct packed {
    ebs_fsm_t fsm;
    logic [16:0] pre;
    logic [8:0] ticks;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] din;
    logic en;
    logic [8:0] rel_dly;
    logic [8:0] acc_dly;
    logic [8:0] stp_dly;
    logic [8:0] cnf_dly;
    logic [15:0] brake_freq;
    logic [15:0] brake_cur;
    logic [7:0][7:0] in_sel;
    logic [4:0][7:0] out_sel;
    logic rel;
    logic flt;
    logic [7:0] code;
    logic [4:0] dout;
    logic [15:0] tgt;
    logic ovr;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ebs_state_t;

endpackage
`default_nettype wire

// ==== ebs_brake_model.sv ====
// Behavioural external brake with its confirmation contact
`timescale 1ns/10ps
`default_nettype none
module ebs_brake_model (
  input wire logic clk, // System clock
  input wire logic release_in, // Release command from the sequencer
  input wire logic [1:0] mode, // 0 good, 1 never opens, 2 never closes
  output var logic confirm_out = 1'b0 // Contact, high while released
);
  logic [2:0] lag = 3'h0; // Mechanical travel time
  ////////////////////////////////////////////////////////////////////////
  // Contact follows the command after travel, or sticks by mode
  always @(posedge clk) begin
    lag <= {lag[1:0], release_in};
    if (mode == 2'h1) begin
      confirm_out <= 1'b0;
    end else if (mode == 2'h2 && confirm_out) begin
      confirm_out <= 1'b1;
    end else begin
      confirm_out <= lag[2];
    end
  end
endmodule
`default_nettype wire

// ==== ebs_sequencer_bench.sv ====
// Self-checking bench for the external brake sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ebs_defines.svh"
module ebs_sequencer_bench;
  localparam int TK = 10; // Cycles per timer tick
  logic clk = 1'b0, rst = 1'b1, run = 1'b0; // Clock, reset, run
  logic [15:0] ofreq = 16'h0000, mcur = 16'h0000; // Motor feedback
  logic [1:0] mode = 2'h0; // Brake behaviour
  logic cnf, rel, flt, ovr, awr, wr, bv, arr, rv; // Design outputs
  logic [4:0] dout; // Mapped outputs
  logic [7:0] code, awa = 8'h00, ara = 8'h00; // Fault code, addresses
  logic [15:0] tgt; // Override target
  logic [31:0] wd = 32'h0, rd; // Bus data
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [1:0] bre, rre; // Responses
  logic [31:0] d; // Read result
  logic [1:0] r; // Response result
  int num_errors = 0, check_count = 0, i, c;
  wire logic [3:0] ws = {tgt === 16'h0, ovr, flt, rel}; // Wait choices
  always #50 clk = ~clk;
  ebs_brake_model ebs_brake_model_i (.clk(clk), .release_in(dout[0]),
    .mode(mode), .confirm_out(cnf));
  ebs_sequencer #(.TICK_CYCLES(TK)) ebs_sequencer_i (
    .CLK(clk), .SYS_RST(rst), .RUN_REQ(run), .OUT_FREQ(ofreq),
    .MOTOR_CUR(mcur), .DIN({5'h00, cnf, 2'h0}), .DOUT(dout),
    .RELEASE_BRAKE_OUT(rel), .BRAKE_FAULT_OUT(flt), .FAULT_CODE(code),
    .FREQ_OVERRIDE(ovr), .FREQ_TARGET(tgt), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(bre), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rre), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr));
  ////////////////////////////////////////////////////////////////////////
  // Compare, verdict, bus cycles and waits
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Write; address and data released each when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wr;
      tb = (bv === 1'b1);
      r = bre;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    br <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    logic ta, tb;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = arv & arr;
      tb = (rv === 1'b1);
      d = rd;
      r = rre;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end
    rr <= 1'b0;
  endtask
  // Count cycles until a chosen output reaches a level
  task automatic wt(input int s, input logic v);
    for (c = 0; ws[s] !== v; c++) @(negedge clk);
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    axr(`EBS_REG_BRAKE_CUR);
    chk("cur_rst", 32'h3E8, d);
    axw(`EBS_REG_BRAKE_FREQ, 32'h1388);
    axr(`EBS_REG_BRAKE_FREQ);
    chk("freq_max", 32'hFA0, d);
    axw(`EBS_REG_BRAKE_CUR, 32'hBB8);
    axr(`EBS_REG_BRAKE_CUR);
    chk("cur_max", 32'h7D0, d);
    axw(8'h30, 32'h1);
    chk("unmap_wr", 32'h2, {30'h0, r});
    axr(8'h30);
    chk("unmap_rd", 32'h2, {30'h0, r});
    axw(8'h48, {24'h0, `EBS_FN_CONFIRM});
    axw(8'h60, {24'h0, `EBS_FN_RELEASE});
    axw(8'h64, {24'h0, `EBS_FN_FAULT});
    for (i = 1; i < 5; i++) axw(8'(4 * i), 32'h3);
    axw(`EBS_REG_BRAKE_FREQ, 32'h32);
    axw(`EBS_REG_BRAKE_CUR, 32'h1F4);
    axw(`EBS_REG_CTRL, 32'h1);
  endtask
  task automatic t_start();
    mcur <= 16'h0258;
    run <= 1'b1;
    wt(2, 1'b1);
    chk("start_tgt", 32'h32, {16'h0, tgt});
    ofreq <= 16'h0032;
    wt(0, 1'b1);
    chk("rel_wait", 32'h1,
        32'(c >= 3 * TK && c <= 3 * TK + 4));
    chk("dout_rel", 32'h1, {27'h0, dout});
    wt(2, 1'b0);
    chk("acc_wait", 32'h1,
        32'(c >= 3 * TK + 7 && c <= 3 * TK + 20));
  endtask
  task automatic t_stop();
    run <= 1'b0;
    ofreq <= 16'h0064;
    wt(2, 1'b1);
    chk("stop_ramp", 32'h10032, {15'h0, rel, tgt});
    ofreq <= 16'h0032;
    wt(0, 1'b0);
    chk("hold_freq", 32'h10032, {15'h0, ovr, tgt});
    wt(3, 1'b1);
    chk("pre_stop", 32'h1,
        32'(c >= 3 * TK + 6 && c <= 3 * TK + 20));
    chk("zero_ovr", 32'h1, {31'h0, ovr});
    ofreq <= 16'h0000;
    wt(2, 1'b0);
  endtask
  task automatic t_fault(input logic [1:0] m, input logic [15:0] cur,
                         input logic [7:0] e);
    mode <= m;
    mcur <= cur;
    run <= 1'b1;
    ofreq <= 16'h0032;
    wt(1, 1'b1);
    chk("flt_code", {24'h0, e}, {24'h0, code});
    chk("flt_pins", 32'h2, {25'h0, ovr, rel, dout});
    run <= 1'b0;
    mode <= 2'h0;
    axw(`EBS_REG_CTRL, 32'h3);
    ofreq <= 16'h0000;
    wt(1, 1'b0);
  endtask
  task automatic t_engage();
    t_start();
    mode <= 2'h2;
    run <= 1'b0;
    ofreq <= 16'h0032;
    wt(1, 1'b1);
    chk("engage", {24'h0, `EBS_CODE_ENGAGE_FAIL}, {24'h0, code});
    mode <= 2'h0;
    axw(`EBS_REG_CTRL, 32'h3);
    ofreq <= 16'h0000;
  endtask
  task automatic t_disable();
    t_start();
    axw(`EBS_REG_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk("disabled", 32'h0, {27'h0, rel, flt, ovr, dout[1:0]});
    run <= 1'b0;
  endtask
  initial begin
    #(100 * 30000);
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("rst_out", 32'h0, {16'h0, rel, flt, ovr, code, dout});
    t_regs();
    t_start();
    t_stop();
    t_fault(2'h0, 16'h0064, 8'h00);
    t_fault(2'h1, 16'h0258, `EBS_CODE_RELEASE_FAIL);
    t_engage();
    t_disable();
    wrap_up();
  end
endmodule
`default_nettype wire
